// *** rmc_rx_ctrl.sv ***
// receive mac/pcs control: config registers, frame gating and lane marker check
`timescale 1ns/1ps
module rmc_rx_ctrl #(
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // decoded receive bytes from the pcs
    input wire logic i_rx_vld,
    input wire logic [7:0] i_rx_dat,
    input wire logic i_rx_sop,
    input wire logic i_rx_eop,
    input wire logic i_rx_fcs_bad,
    // per-lane 64-bit blocks from the pcs
    input wire logic i_lm_vld,
    input wire logic [(LANES > 1 ? $clog2(LANES) : 1)-1:0] i_lm_lane,
    input wire logic [63:0] i_lm_blk,
    // user stream
    output logic o_rx_ena,
    output logic [7:0] o_rx_dat,
    output logic o_rx_sop,
    output logic o_rx_eop,
    output logic o_rx_err,
    // statistics pulses
    output logic o_stat_good,
    output logic o_stat_bad_fcs,
    // pcs control and lane status
    output logic o_rate_40g,
    output logic o_pcs_decode_en,
    output logic o_resync,
    output logic [LANES-1:0] o_lane_locked,
    output logic [LANES-1:0] o_lane_len_err
);
    import rmc_pkg::*;

    localparam int LIW = LANES > 1 ? $clog2(LANES) : 1;
    localparam int DEPTH = RUNT_LEN;

    if (LANES < 1 || LANES > LANES_MAX) begin : g_chk
        $error("rmc_rx_ctrl: LANES must be 1 to 8");
    end

    // configuration state
    logic rx_en, chk_pre, chk_sfd, del_fcs, ign_fcs, rate_40g, hold, resync;
    logic [14:0] max_len;
    logic [7:0] min_len;
    logic [15:0] spacing;
    // frame state
    logic in_frame, in_pre, pre_bad, trunc;
    logic [2:0] pre_cnt;
    logic [14:0] len;
    // delivery line, entry 0 newest
    logic [DEPTH-1:0] ln_vld, ln_sop, ln_eop, ln_err;
    logic [DEPTH-1:0][7:0] ln_dat;
    logic [DEPTH-1:0] next_vld, next_sop, next_eop, next_err;
    logic [DEPTH-1:0][7:0] next_dat;
    // lane checker state
    logic s1_vld;
    logic [LIW-1:0] s1_lane;
    logic [63:0] s1_blk;
    logic [63:0] pat_rd;
    logic [LANES-1:0][15:0] lane_cnt;

    // ---------------- wishbone decode ----------------
    wire wb_req = i_wb_cyc & i_wb_stb;
    // writes land on the edge that also sees ack high
    wire wb_wr = wb_req & i_wb_we & o_wb_ack;
    wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire sel_ctrl = i_wb_adr == ADR_CTRL;
    wire sel_max = i_wb_adr == ADR_MAX_LEN;
    wire sel_min = i_wb_adr == ADR_MIN_LEN;
    wire sel_spc = i_wb_adr == ADR_SPACING;
    wire sel_stat = i_wb_adr == ADR_STATUS;
    wire [7:0] pat_off = i_wb_adr - ADR_PAT_BASE;
    wire sel_pat = (i_wb_adr >= ADR_PAT_BASE) && ({1'b0, pat_off} < 9'(LANES * 8));
    wire wr_ctrl = wb_wr & sel_ctrl & i_wb_sel[0];
    wire [31:0] max_new = ({17'h0, max_len} & ~wmask) | (i_wb_dat & wmask);
    wire [31:0] spc_new = ({16'h0, spacing} & ~wmask) | (i_wb_dat & wmask);
    // pattern halves: low word at +0, high word at +4
    wire [7:0] pat_be = pat_off[2] ? {i_wb_sel, 4'h0} : {4'h0, i_wb_sel};
    wire [LIW-1:0] pat_lane = LIW'(pat_off >> 3);
    wire pat_we = wb_wr & sel_pat & hold;

    // read mux
    logic [31:0] ctrl_rd, stat_rd;
    always_comb begin
        ctrl_rd = 32'h0;
        ctrl_rd[CTRL_RX_EN] = rx_en;
        ctrl_rd[CTRL_CHK_PRE] = chk_pre;
        ctrl_rd[CTRL_CHK_SFD] = chk_sfd;
        ctrl_rd[CTRL_DEL_FCS] = del_fcs;
        ctrl_rd[CTRL_IGN_FCS] = ign_fcs;
        ctrl_rd[CTRL_RATE_40G] = rate_40g;
        ctrl_rd[CTRL_HOLD] = hold;
        stat_rd = 32'h0;
        stat_rd[STAT_LOCK_LSB +: LANES] = o_lane_locked;
        stat_rd[STAT_LEN_ERR_LSB +: LANES] = o_lane_len_err;
        stat_rd[STAT_IN_FRAME] = in_frame;
        stat_rd[STAT_DECODE_EN] = o_pcs_decode_en;
    end
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                         sel_max ? {17'h0, max_len} :
                         sel_min ? {24'h0, min_len} :
                         sel_spc ? {16'h0, spacing} :
                         sel_stat ? stat_rd : 32'h0;

    // single-wait-state ack; unmapped addresses ack with zero
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req & ~o_wb_ack;
            if (wb_req && !o_wb_ack) begin
                o_wb_dat <= rd_mux;
            end
        end
    end

    // control register; static fields only move while held in reset
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {resync, hold, rate_40g, ign_fcs, del_fcs, chk_sfd, chk_pre, rx_en} <= CTRL_RST;
        end else begin
            resync <= wr_ctrl & i_wb_dat[CTRL_RESYNC]; // self-clearing pulse
            if (wr_ctrl) begin
                rx_en <= i_wb_dat[CTRL_RX_EN];
                chk_pre <= i_wb_dat[CTRL_CHK_PRE];
                chk_sfd <= i_wb_dat[CTRL_CHK_SFD];
                ign_fcs <= i_wb_dat[CTRL_IGN_FCS];
                hold <= i_wb_dat[CTRL_HOLD];
                if (hold) begin
                    del_fcs <= i_wb_dat[CTRL_DEL_FCS];
                    rate_40g <= i_wb_dat[CTRL_RATE_40G];
                end
            end
        end
    end

    // length limits and marker spacing
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            max_len <= MAX_LEN_RST;
            min_len <= MIN_LEN_RST;
            spacing <= SPACING_RST;
        end else begin
            if (wb_wr && sel_max) begin
                max_len <= {1'b0, max_new[MAX_LEN_RSVD-1:0]}; // reserved top bit
            end
            if (wb_wr && sel_min && i_wb_sel[0]) begin
                min_len <= i_wb_dat[7:0];
            end
            if (wb_wr && sel_spc && hold) begin
                spacing <= spc_new[15:0];
            end
        end
    end

    // ---------------- frame gating ----------------
    // hold and resync both flush the receive path
    wire clear_rx = hold | resync;
    // a frame only starts while enabled; a running one completes unless hold or resync flushes it
    wire start = i_rx_vld & i_rx_sop & ~in_frame & rx_en & ~clear_rx;
    wire rx_byte = i_rx_vld & in_frame;
    wire [2:0] pre_idx = start ? 3'h0 : pre_cnt;
    wire pre_chk = start | (rx_byte & in_pre);
    wire is_sfd = pre_idx == SFD_IDX;
    wire [7:0] pre_exp = is_sfd ? SFD_BYTE : PRE_BYTE;
    wire pre_on = is_sfd ? chk_sfd : chk_pre;
    wire pre_miss = pre_chk & pre_on & (i_rx_dat != pre_exp);
    wire take = rx_byte & ~in_pre & ~trunc;
    wire [14:0] len_next = len + 15'h1;
    // only a byte past the limit makes a frame oversized; an exact fit ends clean
    wire at_max = take & (len_next == max_len) & ~i_rx_eop;
    wire fb_eop = i_rx_eop | at_max;
    wire fend = rx_byte & ~in_pre & i_rx_eop;
    wire short = take & i_rx_eop & (len_next < 15'(RUNT_LEN));
    wire under = len_next < {7'h0, min_len};
    wire fcs_flag = i_rx_eop & i_rx_fcs_bad & ~ign_fcs;
    wire ferr = fcs_flag | under | at_max | pre_bad;
    // strip only complete frames longer than the no-strip limit
    wire strip = take & i_rx_eop & ~at_max & del_fcs & ~short
                 & (len_next > 15'(NO_STRIP_LEN));

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            in_frame <= 1'b0;
            in_pre <= 1'b0;
            pre_bad <= 1'b0;
            trunc <= 1'b0;
            pre_cnt <= 3'h0;
            len <= 15'h0;
        end else if (clear_rx) begin
            in_frame <= 1'b0;
            in_pre <= 1'b0;
            trunc <= 1'b0;
        end else if (start) begin
            in_frame <= 1'b1;
            in_pre <= 1'b1;
            pre_bad <= pre_miss;
            trunc <= 1'b0;
            pre_cnt <= 3'h1;
            len <= 15'h0;
        end else if (rx_byte) begin
            if (i_rx_eop) begin
                in_frame <= 1'b0;
            end
            if (in_pre) begin
                pre_bad <= pre_bad | pre_miss;
                pre_cnt <= pre_cnt + 3'h1;
                in_pre <= ~is_sfd;
            end
            if (take) begin
                len <= len_next;
                trunc <= at_max; // later bytes dropped
            end
        end
    end

    // delivery line: sixteen entries deep so runts can be withdrawn
    for (genvar i = 0; i < DEPTH; i++) begin : g_line
        logic s_vld, s_sop, s_eop, s_err, kill;
        logic [7:0] s_dat;
        if (i == 0) begin : g_head
            assign s_vld = take;
            assign s_sop = len == 15'h0;
            assign s_eop = fb_eop;
            assign s_err = fb_eop & ferr;
            assign s_dat = i_rx_dat;
        end else begin : g_body
            assign s_vld = ln_vld[i-1];
            assign s_sop = ln_sop[i-1];
            assign s_eop = ln_eop[i-1];
            assign s_err = ln_err[i-1];
            assign s_dat = ln_dat[i-1];
        end
        // runt frames vanish whole; strip drops the last four bytes
        assign kill = (short & (15'(i) < len_next)) | (strip & (i < FCS_LEN));
        assign next_vld[i] = s_vld & ~kill;
        assign next_sop[i] = s_sop;
        assign next_dat[i] = s_dat;
        assign next_eop[i] = (strip && i <= FCS_LEN) ? (i == FCS_LEN) : s_eop;
        assign next_err[i] = (strip && i <= FCS_LEN) ? (i == FCS_LEN) & ferr : s_err;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ln_vld <= '0;
            ln_sop <= '0;
            ln_eop <= '0;
            ln_err <= '0;
            ln_dat <= '0;
        end else begin
            ln_vld <= clear_rx ? '0 : next_vld;
            ln_sop <= next_sop;
            ln_eop <= next_eop;
            ln_err <= next_err;
            ln_dat <= next_dat;
        end
    end

    // a flush also masks the markers, so none stands without enable
    wire out_vld = ln_vld[DEPTH-1] & ~clear_rx;

    // user stream, statistics and pcs control; enable, markers and statistics idle unless a frame was accepted
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_ena <= 1'b0;
            o_rx_dat <= 8'h0;
            o_rx_sop <= 1'b0;
            o_rx_eop <= 1'b0;
            o_rx_err <= 1'b0;
            o_stat_good <= 1'b0;
            o_stat_bad_fcs <= 1'b0;
            o_pcs_decode_en <= 1'b0;
            o_rate_40g <= 1'b0;
            o_resync <= 1'b0;
        end else begin
            o_rx_ena <= out_vld;
            o_rx_dat <= ln_dat[DEPTH-1];
            o_rx_sop <= out_vld & ln_sop[DEPTH-1];
            o_rx_eop <= out_vld & ln_eop[DEPTH-1];
            o_rx_err <= out_vld & ln_eop[DEPTH-1] & ln_err[DEPTH-1];
            o_stat_bad_fcs <= fend & i_rx_fcs_bad & ~clear_rx;
            o_stat_good <= fend & ~clear_rx & ~trunc & ~short & ~ferr;
            o_pcs_decode_en <= (rx_en | in_frame) & ~hold;
            o_rate_40g <= rate_40g;
            o_resync <= resync;
        end
    end

    // ---------------- lane marker check ----------------
    rmc_marker_mem #(
        .WORDS(LANES),
        .AW(LIW)
    ) u_pat (
        .i_clk_sys(i_clk_sys),
        .i_wr_en(pat_we),
        .i_wr_addr(pat_lane),
        .i_wr_be(pat_be),
        .i_wr_dat({i_wb_dat, i_wb_dat}),
        .i_rd_addr(i_lm_lane),
        .o_rd_dat(pat_rd)
    );

    // block waits one cycle for its lane's pattern
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_vld <= 1'b0;
            s1_lane <= '0;
            s1_blk <= 64'h0;
        end else begin
            s1_vld <= i_lm_vld & ~clear_rx;
            s1_lane <= i_lm_lane;
            s1_blk <= i_lm_blk;
        end
    end

    wire lm_hit = s1_blk == pat_rd;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        wire mine = s1_vld & (s1_lane == LIW'(l));
        wire due = lane_cnt[l] == spacing; // period is spacing plus one
        always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
                lane_cnt[l] <= 16'h0;
                o_lane_locked[l] <= 1'b0;
                o_lane_len_err[l] <= 1'b0;
            end else if (clear_rx) begin
                lane_cnt[l] <= 16'h0;
                o_lane_locked[l] <= 1'b0;
                o_lane_len_err[l] <= 1'b0;
            end else if (mine && lm_hit) begin
                lane_cnt[l] <= 16'h0;
                o_lane_locked[l] <= 1'b1;
                o_lane_len_err[l] <= o_lane_locked[l] & ~due;
            end else if (mine) begin
                // a missing marker when due drops lock
                lane_cnt[l] <= due ? 16'h0 : lane_cnt[l] + 16'h1;
                if (due && o_lane_locked[l]) begin
                    o_lane_len_err[l] <= 1'b1;
                    o_lane_locked[l] <= 1'b0;
                end
            end
        end
    end
endmodule

// *** rmc_pkg.sv ***
// shared constants for the receive mac/pcs control block
package rmc_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_MAX_LEN = 8'h04;
    localparam logic [7:0] ADR_MIN_LEN = 8'h08;
    localparam logic [7:0] ADR_SPACING = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_PAT_BASE = 8'h20;
    localparam logic [7:0] PAT_STRIDE = 8'h08;

    // control register bit positions
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_CHK_PRE = 1;
    localparam int CTRL_CHK_SFD = 2;
    localparam int CTRL_DEL_FCS = 3;
    localparam int CTRL_IGN_FCS = 4;
    localparam int CTRL_RATE_40G = 5;
    localparam int CTRL_HOLD = 6;
    localparam int CTRL_RESYNC = 7;

    // status register bit positions
    localparam int STAT_LOCK_LSB = 0;
    localparam int STAT_LEN_ERR_LSB = 8;
    localparam int STAT_IN_FRAME = 16;
    localparam int STAT_DECODE_EN = 17;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [14:0] MAX_LEN_RST = 15'h05EE;
    localparam logic [7:0] MIN_LEN_RST = 8'h40;
    localparam logic [15:0] SPACING_RST = 16'h3FFF;

    // frame layout figures
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [2:0] SFD_IDX = 3'h7;
    localparam int RUNT_LEN = 16;
    localparam int FCS_LEN = 4;
    localparam int NO_STRIP_LEN = 8;
    localparam int MAX_LEN_RSVD = 14;
    localparam int LANES_MAX = 8;
endpackage

// *** rmc_marker_mem.sv ***
// lane marker pattern store, byte-writable, registered read
`timescale 1ns/1ps
module rmc_marker_mem #(
    parameter int WORDS = 4,
    parameter int AW = 2
) (
    // clock
    input wire logic i_clk_sys,
    // write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [7:0] i_wr_be,
    input wire logic [63:0] i_wr_dat,
    // read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [63:0] o_rd_dat
);
    logic [63:0] mem [WORDS];

    // one write strobe per byte lane
    for (genvar b = 0; b < 8; b++) begin : g_byte
        always_ff @(posedge i_clk_sys) begin
            if (i_wr_en && i_wr_be[b]) begin
                mem[i_wr_addr][b*8 +: 8] <= i_wr_dat[b*8 +: 8];
            end
        end
    end

    // no reset: contents are undefined until software loads them
    always_ff @(posedge i_clk_sys) begin
        o_rd_dat <= mem[i_rd_addr];
    end
endmodule

// *** rmc_rx_ctrl_asserts.sv ***
// concurrent checks on the receive control block ports
`timescale 1ns/1ps
module rmc_rx_ctrl_asserts #(
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // bus and receive inputs
    input wire logic o_wb_ack,
    input wire logic i_rx_vld,
    input wire logic [7:0] i_rx_dat,
    input wire logic i_rx_eop,
    input wire logic i_rx_fcs_bad,
    input wire logic i_lm_vld,
    input wire logic [(LANES > 1 ? $clog2(LANES) : 1)-1:0] i_lm_lane,
    // outputs under watch
    input wire logic o_rx_ena,
    input wire logic [7:0] o_rx_dat,
    input wire logic o_rx_eop,
    input wire logic o_rx_err,
    input wire logic o_stat_good,
    input wire logic o_stat_bad_fcs,
    input wire logic o_rate_40g,
    input wire logic o_resync,
    input wire logic [LANES-1:0] o_lane_locked,
    input wire logic [LANES-1:0] o_lane_len_err
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    // resync comes from a control write and lasts one cycle only
    sequence s_one_pulse;
        ($past(o_wb_ack) || $past(o_wb_ack, 2)) ##1 !o_resync;
    endsequence

    a_err_at_eop: assert property (
        o_rx_err |-> o_rx_ena && o_rx_eop) else $error("err outside final transfer");
    a_data_latency: assert property (
        o_rx_ena |-> $past(i_rx_vld, 17) && o_rx_dat == $past(i_rx_dat, 17))
        else $error("delivered byte not the one taken 17 cycles before");
    a_bad_fcs_cause: assert property (
        o_stat_bad_fcs |-> $past(i_rx_vld && i_rx_eop && i_rx_fcs_bad))
        else $error("bad fcs stat without bad frame end");
    a_good_cause: assert property (
        o_stat_good |-> $past(i_rx_vld && i_rx_eop)) else $error("good stat without frame end");
    a_rate_by_write: assert property (
        $changed(o_rate_40g) |-> $past(o_wb_ack) || $past(o_wb_ack, 2))
        else $error("rate select moved without a bus write");
    a_resync_pulse: assert property (
        o_resync |-> s_one_pulse) else $error("resync not a single written pulse");
    a_lock_cause: assert property (
        $rose(o_lane_locked[0]) |-> $past(i_lm_vld && i_lm_lane == '0, 2))
        else $error("lane lock without a lane block");
    a_len_err_cause: assert property (
        $rose(o_lane_len_err[0]) |-> $past(i_lm_vld && i_lm_lane == '0, 2))
        else $error("spacing error without a lane block");
endmodule

bind rmc_rx_ctrl rmc_rx_ctrl_asserts #(.LANES(LANES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .o_wb_ack(o_wb_ack), .i_rx_vld(i_rx_vld),
    .i_rx_dat(i_rx_dat), .i_rx_eop(i_rx_eop), .i_rx_fcs_bad(i_rx_fcs_bad),
    .i_lm_vld(i_lm_vld), .i_lm_lane(i_lm_lane), .o_rx_ena(o_rx_ena), .o_rx_dat(o_rx_dat),
    .o_rx_eop(o_rx_eop), .o_rx_err(o_rx_err), .o_stat_good(o_stat_good),
    .o_stat_bad_fcs(o_stat_bad_fcs), .o_rate_40g(o_rate_40g), .o_resync(o_resync),
    .o_lane_locked(o_lane_locked), .o_lane_len_err(o_lane_len_err));

// *** rmc_link_model.sv ***
// link partner model: byte frames and lane blocks toward the receiver
`timescale 1ns/1ps
module rmc_link_model #(
    parameter int LANES = 4,
    parameter int LW = (LANES > 1 ? $clog2(LANES) : 1)
) (
    // clock
    input wire logic i_clk_sys,
    // decoded byte stream
    output logic o_rx_vld = 1'b0,
    output logic [7:0] o_rx_dat = 8'h00,
    output logic o_rx_sop = 1'b0,
    output logic o_rx_eop = 1'b0,
    output logic o_rx_fcs_bad = 1'b0,
    // lane blocks
    output logic o_lm_vld = 1'b0,
    output logic [LW-1:0] o_lm_lane = '0,
    output logic [63:0] o_lm_blk = 64'h0
);
    // contiguous frame; mode 1 spoils the preamble, mode 2 the delimiter
    task automatic send(input int n, input bit bad, input int mode);
        for (int i = 0; i < n + 8; i++) begin
            @(posedge i_clk_sys);
            o_rx_vld <= 1'b1;
            o_rx_sop <= (i == 0);
            o_rx_eop <= (i == n + 7);
            o_rx_fcs_bad <= bad && (i == n + 7);
            o_rx_dat <= (i < 7) ? ((mode == 1 && i == 3) ? 8'h54 : 8'h55) :
                (i == 7) ? ((mode == 2) ? 8'hD4 : 8'hD5) : 8'(i - 8);
        end
        @(posedge i_clk_sys);
        o_rx_vld <= 1'b0;
        o_rx_sop <= 1'b0;
        o_rx_eop <= 1'b0;
        o_rx_fcs_bad <= 1'b0;
        // released data shows the inverse, never a stale byte
        o_rx_dat <= ~o_rx_dat;
    endtask

    // one block on one lane
    task automatic blk(input int lane, input logic [63:0] b);
        @(posedge i_clk_sys);
        o_lm_vld <= 1'b1;
        o_lm_lane <= LW'(lane);
        o_lm_blk <= b;
        @(posedge i_clk_sys);
        o_lm_vld <= 1'b0;
        o_lm_blk <= ~b;
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the receive control block
`timescale 1ns/1ps
module tb_top;
    import rmc_pkg::*;
    localparam int LANES = 4;
    localparam logic [63:0] PAT = 64'h0123_4567_89AB_CDEF;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, o_wb_ack;
    logic [7:0] i_wb_adr = 8'h00, i_rx_dat, o_rx_dat;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
    logic i_rx_vld, i_rx_sop, i_rx_eop, i_rx_fcs_bad, i_lm_vld, er;
    logic [1:0] i_lm_lane;
    logic [63:0] i_lm_blk;
    logic o_rx_ena, o_rx_sop, o_rx_eop, o_rx_err, o_stat_good, o_stat_bad_fcs;
    logic o_rate_40g, o_pcs_decode_en, o_resync;
    logic [LANES-1:0] o_lane_locked, o_lane_len_err;
    int failures = 0, total_checks = 0, nb, ng, nbad, ns, ne, nrs = 0;

    // 200 MHz
    always #2.5 i_clk_sys = ~i_clk_sys;

    rmc_rx_ctrl #(.LANES(LANES)) dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_rx_vld(i_rx_vld), .i_rx_dat(i_rx_dat), .i_rx_sop(i_rx_sop), .i_rx_eop(i_rx_eop),
        .i_rx_fcs_bad(i_rx_fcs_bad), .i_lm_vld(i_lm_vld), .i_lm_lane(i_lm_lane),
        .i_lm_blk(i_lm_blk), .o_rx_ena(o_rx_ena), .o_rx_dat(o_rx_dat), .o_rx_sop(o_rx_sop),
        .o_rx_eop(o_rx_eop), .o_rx_err(o_rx_err), .o_stat_good(o_stat_good),
        .o_stat_bad_fcs(o_stat_bad_fcs), .o_rate_40g(o_rate_40g),
        .o_pcs_decode_en(o_pcs_decode_en), .o_resync(o_resync),
        .o_lane_locked(o_lane_locked), .o_lane_len_err(o_lane_len_err));

    rmc_link_model #(.LANES(LANES)) lnk (.i_clk_sys(i_clk_sys), .o_rx_vld(i_rx_vld),
        .o_rx_dat(i_rx_dat), .o_rx_sop(i_rx_sop), .o_rx_eop(i_rx_eop),
        .o_rx_fcs_bad(i_rx_fcs_bad), .o_lm_vld(i_lm_vld), .o_lm_lane(i_lm_lane),
        .o_lm_blk(i_lm_blk));

    // tally delivered bytes and pulses; pre-edge values are settled
    always @(posedge i_clk_sys) begin
        if (o_rx_ena === 1'b1) nb++;
        if (o_rx_ena === 1'b1 && o_rx_sop === 1'b1) ns++;
        if (o_rx_ena === 1'b1 && o_rx_eop === 1'b1) ne++;
        if (o_rx_ena === 1'b1 && o_rx_eop === 1'b1) er = o_rx_err;
        if (o_stat_good === 1'b1) ng++;
        if (o_stat_bad_fcs === 1'b1) nbad++;
        if (o_resync === 1'b1) nrs++;
    end

    task automatic test_done();
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // classic cycle held until ack is sampled; no latency assumed
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        i_wb_sel <= 4'hF;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        if (n >= 50) begin
            failures++;
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk($sformatf("register %h", a), e, rd);
    endtask

    // one frame, then bytes out, end error and both statistics
    task automatic fr(input int n, input bit bad, input int mode, input int eb,
            input logic ee, input int eg, input int ebf);
        nb = 0;
        ng = 0;
        nbad = 0;
        ns = 0;
        ne = 0;
        er = 1'b0;
        lnk.send(n, bad, mode);
        repeat (20) @(posedge i_clk_sys);
        chk("bytes", 32'(eb), 32'(nb));
        chk("sop count", 32'(eb > 0), 32'(ns));
        chk("eop count", 32'(eb > 0), 32'(ne));
        chk("end error", {31'h0, ee}, {31'h0, er});
        chk("good stat", 32'(eg), 32'(ng));
        chk("bad fcs stat", 32'(ebf), 32'(nbad));
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        rc(ADR_CTRL, 32'h40);
        rc(ADR_MAX_LEN, 32'h5EE);
        rc(ADR_MIN_LEN, 32'h40);
        rc(ADR_SPACING, 32'h3FFF);
        rc(8'h3C, 32'h0);
        wr(ADR_MAX_LEN, 32'h7FFF);
        rc(ADR_MAX_LEN, 32'h3FFF);
        wr(ADR_MAX_LEN, 32'h40);
        wr(ADR_MIN_LEN, 32'h20);
        wr(ADR_SPACING, 32'h3);
        wr(ADR_PAT_BASE, PAT[31:0]);
        wr(8'h24, PAT[63:32]);
        wr(ADR_CTRL, 32'h66);
        wr(ADR_CTRL, 32'h27);
        repeat (3) @(posedge i_clk_sys);
        chk("rate", 32'h1, {31'h0, o_rate_40g});
        chk("decode", 32'h1, {31'h0, o_pcs_decode_en});
        fr(40, 0, 0, 40, 0, 1, 0);
        fr(40, 1, 0, 40, 1, 0, 1);
        fr(20, 0, 0, 20, 1, 0, 0);
        fr(15, 1, 0, 0, 0, 0, 1);
        fr(70, 0, 0, 64, 1, 0, 0);
        fr(64, 0, 0, 64, 0, 1, 0);
        fr(40, 0, 1, 40, 1, 0, 0);
        fr(40, 0, 2, 40, 1, 0, 0);
        wr(ADR_CTRL, 32'h37);
        fr(40, 1, 0, 40, 0, 1, 1);
        // first marker locks, spacing 3 is kept, then broken short
        lnk.blk(0, PAT);
        for (int k = 0; k < 3; k++) lnk.blk(0, 64'h0);
        lnk.blk(0, PAT);
        repeat (3) @(posedge i_clk_sys);
        chk("locked", 32'h1, {31'h0, o_lane_locked[0]});
        chk("len err", 32'h0, {31'h0, o_lane_len_err[0]});
        for (int k = 0; k < 2; k++) lnk.blk(0, 64'h0);
        lnk.blk(0, PAT);
        repeat (3) @(posedge i_clk_sys);
        chk("len err", 32'h1, {31'h0, o_lane_len_err[0]});
        wr(ADR_CTRL, 32'h67);
        wr(ADR_CTRL, 32'h6F);
        wr(ADR_CTRL, 32'h2F);
        fr(40, 0, 0, 36, 0, 1, 0);
        // disable lands mid-frame; the open frame still completes
        fork
            fr(40, 0, 0, 36, 0, 1, 0);
            begin
                repeat (20) @(posedge i_clk_sys);
                wr(ADR_CTRL, 32'h2E);
            end
        join
        chk("decode", 32'h0, {31'h0, o_pcs_decode_en});
        fr(40, 0, 0, 0, 0, 0, 0);
        wr(ADR_CTRL, 32'hA7);
        repeat (3) @(posedge i_clk_sys);
        chk("resync", 32'h1, 32'(nrs));
        test_done();
    end
endmodule
